// File: verilog/led_pwm_mode_defs.vh
// register offsets, field positions, masks and reset values for the led matrix pwm mode block
// assumes byte addressing on a 32-bit ahb-lite bus, byte registers packed into aligned words
`ifndef LED_PWM_MODE_DEFS_VH
`define LED_PWM_MODE_DEFS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFS_PWM_WORD 8'h08
`define OFS_LED_CONTROL_WORD 8'h0C
`define OFS_IRQ_STATUS 8'h10
`define OFS_IRQ_MASK 8'h14
`define OFS_ROW_SELECT 8'h18
`define OFS_OUTPUT_CTRL 8'h1C

// ----------------------------------------------------------------
// byte lanes inside the words
// ----------------------------------------------------------------
`define PWM_MODE_LSB 24
`define FUNC_CTRL_LSB 0
`define ANALOG_LSB 8
`define PERIOD_LSB 16
`define FRAME_LSB 24

// ----------------------------------------------------------------
// pwm_colour_pin_mode fields
// ----------------------------------------------------------------
`define PM_BLUE_EN 6
`define PM_GREEN_EN 5
`define PM_RED_EN 4
`define PM_ARR_MSB 2
`define PM_ARR_LSB 0
`define PM_WRITE_MASK 8'h77

// ----------------------------------------------------------------
// led_function_control fields
// ----------------------------------------------------------------
`define FC_ROW_END_IRQ_EN 7
`define FC_RED_HALVE 6
`define FC_COM_AHEAD_MSB 4
`define FC_COM_AHEAD_LSB 3
`define FC_AUTO_SHUTOFF 2
`define FC_FULL_LUMA 1
`define FC_CLOCK_GATE 0
`define FC_WRITE_MASK 8'hDF
`define ANALOG_WRITE_MASK 8'hF0
`define PERIOD_WRITE_MASK 8'h73
`define FRAME_WRITE_MASK 8'hF7
`define PERIOD_DIV_MSB 1
`define PERIOD_DIV_LSB 0

// ----------------------------------------------------------------
// status, mask and output control
// ----------------------------------------------------------------
`define ST_ROW_END 7
`define OC_PWM_OE 0
`define REG_RESET 8'h00

// ----------------------------------------------------------------
// pin arrangement codes
// ----------------------------------------------------------------
`define ARR_BOTH_PORTS_24PIN 3'h0
`define ARR_PORT_A_24PIN 3'h1
`define ARR_PORT_B_24PIN 3'h2
`define ARR_SPLIT_16_PLUS_8 3'h3
`define ARR_PORT_A_15PIN 3'h4
`define ARR_MONOCHROME_16PIN 3'h6

// ----------------------------------------------------------------
// com pre-opening codes
// ----------------------------------------------------------------
`define COM_AS_SCHEDULED 2'h0
`define COM_EARLY_ON_OFF 2'h1
`define COM_IMMEDIATE_ON 2'h2
`define COM_IMMEDIATE_EARLY_OFF 2'h3

// ----------------------------------------------------------------
// row timing in led clock ticks
// ----------------------------------------------------------------
`define ROW_GAP_TICKS 4
`define PWM_STEPS 256

`endif

// File: verilog/led_row_timer.v
// row timer: counts led clock ticks through one scanned row
// assumes tick_i is a one-cycle enable already gated by the led clock gate
`timescale 1ns/1ps
`default_nettype none
`include "led_pwm_mode_defs.vh"

module led_row_timer #(
	parameter GAP = `ROW_GAP_TICKS,
	parameter STEPS = `PWM_STEPS
) (
	// clock and reset
	input wire clk_i,
	input wire arst_n_i,
	// control
	input wire tick_i,
	input wire restart_i,
	input wire [1:0] com_ahead_i,
	// timing outputs
	output wire [7:0] pwm_cnt_o,
	output wire display_o,
	output reg com_on_o,
	output wire row_end_o
);

	localparam LAST = GAP + STEPS - 1;

	reg [9:0] tick_cnt;
	wire [9:0] disp_cnt;
	wire at_last;

	assign at_last = (tick_cnt == LAST[9:0]);
	assign row_end_o = tick_i & at_last;
	assign display_o = (tick_cnt >= GAP[9:0]);
	assign disp_cnt = tick_cnt - GAP[9:0];
	assign pwm_cnt_o = display_o ? disp_cnt[7:0] : 8'h00;

	// ----------------------------------------------------------------
	// tick counter
	// ----------------------------------------------------------------
	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			tick_cnt <= 10'h000;
		end else if (restart_i) begin
			tick_cnt <= 10'h000;
		end else if (tick_i) begin
			tick_cnt <= at_last ? 10'h000 : tick_cnt + 10'h001;
		end
	end

	// ----------------------------------------------------------------
	// com window per pre-opening mode
	// ----------------------------------------------------------------
	always @* begin
		case (com_ahead_i)
			`COM_AS_SCHEDULED: com_on_o = display_o;
			`COM_EARLY_ON_OFF: com_on_o = (tick_cnt >= GAP[9:0] - 10'h001) && !at_last;
			`COM_IMMEDIATE_ON: com_on_o = 1'b1;
			`COM_IMMEDIATE_EARLY_OFF: com_on_o = !at_last;
			default: com_on_o = display_o;
		endcase
	end

endmodule

`default_nettype wire

// File: verilog/led_matrix_pwm_mode_ctrl.v
// led matrix pwm mode control: registers, column pwm, pin mapping and com row drive
// assumes a single ahb-lite master, colour levels from logic on the same clock
//
// What this block does
// - Blue, green and red column groups each have their own read-write enable at bits 6, 5, 4.
// - A 3-bit pin-arrangement field at bits 2..0 picks which port pins carry each colour.
// - With the row-end interrupt enable set, every finished row sets the row-end flag, which raises the led interrupt when its mask bit is set.
// - With red halving set, the red pwm runs from half the red data value.
// - The 2-bit com pre-opening field shifts when the row line turns on and off.
// - With auto shutoff set, the pwm output enable is cleared on each row end while the row-end interrupt enable is set, masked or not.
// - With forced full luminance set, luminance is full so colour data alone sets brightness.
// - Bit 0 of function control gates the led clock and resets to zero.
// - The control word at 0x0C packs function, analog, period and frame bytes low to high.
// - A row-end flag sets per row while the row-end interrupt enable is set and clears on a one written to it or a row-select write.
//
// Design decision made here: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "led_pwm_mode_defs.vh"

module led_matrix_pwm_mode_ctrl #(
	parameter ROWS = 8,
	parameter ROW_W = 3
) (
	// clock and reset
	input wire clk_i,
	input wire arst_n_i,
	// ahb-lite slave
	input wire hsel_i,
	input wire [7:0] haddr_i,
	input wire [1:0] htrans_i,
	input wire hwrite_i,
	input wire [2:0] hsize_i,
	input wire hready_i,
	input wire [31:0] hwdata_i,
	output reg [31:0] hrdata_o,
	output reg hreadyout_o,
	output reg hresp_o,
	// colour and luminance levels
	input wire [7:0] red_level_i,
	input wire [7:0] green_level_i,
	input wire [7:0] blue_level_i,
	input wire [7:0] luma_level_i,
	// matrix pins
	output reg [23:0] port_a_o,
	output reg [23:0] port_b_o,
	output reg [ROWS-1:0] com_o,
	// interrupt
	output reg led_irq_o
);

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	reg [7:0] pwm_colour_pin_mode;
	reg [7:0] led_function_control;
	reg [7:0] analog_drive_control;
	reg [7:0] period_configuration;
	reg [7:0] frame_configuration;
	reg [7:0] irq_status;
	reg [7:0] irq_mask;
	reg pwm_oe;
	reg [ROW_W-1:0] row_index;

	// ----------------------------------------------------------------
	// bus phase capture
	// ----------------------------------------------------------------
	reg wr_pending;
	reg [7:0] wr_addr;
	wire addr_phase;
	wire wr_data_phase;
	wire [31:0] wdata;

	assign addr_phase = hsel_i & hready_i & htrans_i[1];
	assign wr_data_phase = wr_pending;
	assign wdata = hwdata_i;

	function wr_hit;
		input [7:0] offset;
		begin
			wr_hit = wr_data_phase && (wr_addr == offset);
		end
	endfunction

	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			wr_pending <= 1'b0;
			wr_addr <= 8'h00;
		end else if (hready_i) begin
			wr_pending <= addr_phase & hwrite_i;
			wr_addr <= {haddr_i[7:2], 2'b00};
		end
	end

	// only whole-word transfers are expected, so hsize is not decoded further
	wire unused_size;
	assign unused_size = ^hsize_i;

	// ----------------------------------------------------------------
	// read data, captured in the address phase
	// ----------------------------------------------------------------
	reg [31:0] next_rdata;

	always @* begin
		next_rdata = 32'h00000000;
		case ({haddr_i[7:2], 2'b00})
			`OFS_PWM_WORD: next_rdata[`PWM_MODE_LSB+7:`PWM_MODE_LSB] = pwm_colour_pin_mode;
			`OFS_LED_CONTROL_WORD: next_rdata = {frame_configuration, period_configuration,
				analog_drive_control, led_function_control};
			`OFS_IRQ_STATUS: next_rdata[7:0] = irq_status;
			`OFS_IRQ_MASK: next_rdata[7:0] = irq_mask;
			`OFS_ROW_SELECT: next_rdata[ROW_W-1:0] = row_index;
			`OFS_OUTPUT_CTRL: next_rdata[`OC_PWM_OE] = pwm_oe;
			default: next_rdata = 32'h00000000;
		endcase
	end

	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			hrdata_o <= 32'h00000000;
			hreadyout_o <= 1'b1;
			hresp_o <= 1'b0;
		end else begin
			hreadyout_o <= 1'b1;
			hresp_o <= 1'b0;
			if (addr_phase && !hwrite_i) begin
				hrdata_o <= next_rdata;
			end
		end
	end

	// ----------------------------------------------------------------
	// mode and control bytes
	// ----------------------------------------------------------------
	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pwm_colour_pin_mode <= `REG_RESET;
			led_function_control <= `REG_RESET;
			analog_drive_control <= `REG_RESET;
			period_configuration <= `REG_RESET;
			frame_configuration <= `REG_RESET;
			irq_mask <= `REG_RESET;
		end else begin
			if (wr_hit(`OFS_PWM_WORD)) begin
				pwm_colour_pin_mode <= wdata[`PWM_MODE_LSB+7:`PWM_MODE_LSB] & `PM_WRITE_MASK;
			end
			if (wr_hit(`OFS_LED_CONTROL_WORD)) begin
				led_function_control <= wdata[`FUNC_CTRL_LSB+7:`FUNC_CTRL_LSB] & `FC_WRITE_MASK;
				analog_drive_control <= wdata[`ANALOG_LSB+7:`ANALOG_LSB] & `ANALOG_WRITE_MASK;
				period_configuration <= wdata[`PERIOD_LSB+7:`PERIOD_LSB] & `PERIOD_WRITE_MASK;
				frame_configuration <= wdata[`FRAME_LSB+7:`FRAME_LSB] & `FRAME_WRITE_MASK;
			end
			if (wr_hit(`OFS_IRQ_MASK)) begin
				irq_mask <= wdata[7:0] & (8'h01 << `ST_ROW_END);
			end
		end
	end

	// ----------------------------------------------------------------
	// field decode
	// ----------------------------------------------------------------
	wire blue_en;
	wire green_en;
	wire red_en;
	wire [2:0] arrangement;
	wire row_irq_en;
	wire red_halve;
	wire [1:0] com_ahead;
	wire auto_shutoff;
	wire full_luma;
	wire clock_gate;
	wire [1:0] div_sel;

	assign blue_en = pwm_colour_pin_mode[`PM_BLUE_EN];
	assign green_en = pwm_colour_pin_mode[`PM_GREEN_EN];
	assign red_en = pwm_colour_pin_mode[`PM_RED_EN];
	assign arrangement = pwm_colour_pin_mode[`PM_ARR_MSB:`PM_ARR_LSB];
	assign row_irq_en = led_function_control[`FC_ROW_END_IRQ_EN];
	assign red_halve = led_function_control[`FC_RED_HALVE];
	assign com_ahead = led_function_control[`FC_COM_AHEAD_MSB:`FC_COM_AHEAD_LSB];
	assign auto_shutoff = led_function_control[`FC_AUTO_SHUTOFF];
	assign full_luma = led_function_control[`FC_FULL_LUMA];
	assign clock_gate = led_function_control[`FC_CLOCK_GATE];
	assign div_sel = period_configuration[`PERIOD_DIV_MSB:`PERIOD_DIV_LSB];

	// ----------------------------------------------------------------
	// led clock: a gated tick divided by 1 to 4
	// ----------------------------------------------------------------
	reg [1:0] div_cnt;
	wire led_tick;

	// stopping the gate holds the row counters and clears the divider, so resuming picks up mid-row
	assign led_tick = clock_gate && (div_cnt == div_sel);

	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			div_cnt <= 2'h0;
		end else if (!clock_gate) begin
			div_cnt <= 2'h0;
		end else begin
			div_cnt <= led_tick ? 2'h0 : div_cnt + 2'h1;
		end
	end

	// ----------------------------------------------------------------
	// row timer
	// ----------------------------------------------------------------
	wire row_sel_write;
	wire [7:0] pwm_cnt;
	wire display;
	wire com_on;
	wire row_end;

	assign row_sel_write = wr_hit(`OFS_ROW_SELECT);

	led_row_timer #(
		.GAP(`ROW_GAP_TICKS),
		.STEPS(`PWM_STEPS)
	) u_row_timer (
		.clk_i(clk_i),
		.arst_n_i(arst_n_i),
		.tick_i(led_tick),
		.restart_i(row_sel_write),
		.com_ahead_i(com_ahead),
		.pwm_cnt_o(pwm_cnt),
		.display_o(display),
		.com_on_o(com_on),
		.row_end_o(row_end)
	);

	// ----------------------------------------------------------------
	// row index: advances per row, software may force it
	// ----------------------------------------------------------------
	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			row_index <= {ROW_W{1'b0}};
		end else if (row_sel_write) begin
			row_index <= wdata[ROW_W-1:0];
		end else if (row_end) begin
			row_index <= (row_index == ROWS - 1) ? {ROW_W{1'b0}} : row_index + 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// row-end flag and interrupt
	// ----------------------------------------------------------------
	wire row_event;
	wire flag_clear;

	assign row_event = row_end & row_irq_en;
	// a write of one or a row-select write clears; a same-cycle row end still wins
	assign flag_clear = (wr_hit(`OFS_IRQ_STATUS) && wdata[`ST_ROW_END]) || row_sel_write;

	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			irq_status <= `REG_RESET;
			led_irq_o <= 1'b0;
		end else begin
			if (row_event) begin
				irq_status[`ST_ROW_END] <= 1'b1;
			end else if (flag_clear) begin
				irq_status[`ST_ROW_END] <= 1'b0;
			end
			led_irq_o <= |(irq_status & irq_mask);
		end
	end

	// ----------------------------------------------------------------
	// pwm global output enable
	// ----------------------------------------------------------------
	// the automatic clear beats a software set in the same cycle so the
	// row switch is always dark
	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pwm_oe <= 1'b0;
		end else if (row_event && auto_shutoff) begin
			pwm_oe <= 1'b0;
		end else if (wr_hit(`OFS_OUTPUT_CTRL)) begin
			pwm_oe <= wdata[`OC_PWM_OE];
		end
	end

	// ----------------------------------------------------------------
	// column pwm
	// ----------------------------------------------------------------
	wire [7:0] red_data;
	wire luma_on;
	wire lit;
	wire red_on;
	wire green_on;
	wire blue_on;

	assign red_data = red_halve ? {1'b0, red_level_i[7:1]} : red_level_i;
	assign luma_on = full_luma || (pwm_cnt < luma_level_i);
	assign lit = pwm_oe && display && luma_on;
	assign red_on = lit && red_en && (pwm_cnt < red_data);
	assign green_on = lit && green_en && (pwm_cnt < green_level_i);
	assign blue_on = lit && blue_en && (pwm_cnt < blue_level_i);

	// ----------------------------------------------------------------
	// pin arrangement
	// ----------------------------------------------------------------
	// every column of a colour group shares one level; returns {port b, port a}
	function [47:0] map_pins;
		input [2:0] arr;
		input r;
		input g;
		input b;
		reg [23:0] rgb;
		reg [23:0] pa;
		reg [23:0] pb;
		begin
			rgb = {{8{b}}, {8{g}}, {8{r}}};
			pa = 24'h000000;
			pb = 24'h000000;
			case (arr)
				`ARR_BOTH_PORTS_24PIN: begin
					pa = rgb;
					pb = rgb;
				end
				`ARR_PORT_A_24PIN: begin
					pa = rgb;
				end
				`ARR_PORT_B_24PIN: begin
					pb = rgb;
				end
				`ARR_SPLIT_16_PLUS_8: begin
					pb[15:0] = rgb[15:0];
					pa[23:16] = rgb[23:16];
				end
				`ARR_PORT_A_15PIN: begin
					pa[4:0] = {5{r}};
					pa[12:8] = {5{g}};
					pa[7:6] = {2{b}};
					pa[15:13] = {3{b}};
				end
				`ARR_MONOCHROME_16PIN: begin
					// colour data drives luminance, so one level lights all 16 pins
					pa[15:0] = {16{r}};
				end
				default: begin
					pa = 24'h000000;
					pb = 24'h000000;
				end
			endcase
			map_pins = {pb, pa};
		end
	endfunction

	wire [47:0] pins;

	assign pins = map_pins(arrangement, red_on, green_on, blue_on);

	// ----------------------------------------------------------------
	// registered pin outputs
	// ----------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < ROWS; gi = gi + 1) begin : g_com
			always @(posedge clk_i or negedge arst_n_i) begin
				if (!arst_n_i) begin
					com_o[gi] <= 1'b0;
				end else begin
					com_o[gi] <= clock_gate && com_on && (row_index == gi);
				end
			end
		end
	endgenerate

	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			port_a_o <= 24'h000000;
			port_b_o <= 24'h000000;
		end else begin
			port_a_o <= pins[23:0];
			port_b_o <= pins[47:24];
		end
	end

endmodule

`default_nettype wire

// File: bench/led_pwm_mode_asserts.sv
// concurrent checks for the led matrix pwm mode block, bound to its top module
// assumes zero-wait ahb-lite writes whose data arrives one cycle after the address
`timescale 1ns/1ps
`default_nettype none
`include "led_pwm_mode_defs.vh"

module led_pwm_mode_asserts #(
	parameter ROWS = 8
) (
	// clock, reset and bus
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic hsel_i,
	input wire logic [7:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic hready_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hreadyout_o,
	input wire logic hresp_o,
	// levels and pins
	input wire logic [7:0] luma_level_i,
	input wire logic [23:0] port_a_o,
	input wire logic [23:0] port_b_o,
	input wire logic [ROWS-1:0] com_o,
	input wire logic led_irq_o
);
	// ----------------------------------------------------------------
	// shadow of the written configuration
	// ----------------------------------------------------------------
	logic wr_pend;
	logic [7:0] wr_addr;
	logic [7:0] pm;
	logic [7:0] func;
	logic [3:0] cfg_age;
	logic live;
	logic dark;

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
			pm <= 8'h00;
			func <= 8'h00;
			cfg_age <= 4'h0;
		end else begin
			wr_pend <= hsel_i && hready_i && htrans_i[1] && hwrite_i;
			if (hsel_i && hready_i && htrans_i[1]) begin
				wr_addr <= haddr_i;
			end
			if (wr_pend && wr_addr == `OFS_PWM_WORD) begin
				pm <= hwdata_i[31:24] & `PM_WRITE_MASK;
			end
			if (wr_pend && wr_addr == `OFS_LED_CONTROL_WORD) begin
				func <= hwdata_i[7:0] & `FC_WRITE_MASK;
			end
			if (wr_pend && (wr_addr == `OFS_PWM_WORD || wr_addr == `OFS_LED_CONTROL_WORD)) begin
				cfg_age <= 4'h0;
			end else if (cfg_age != 4'hF) begin
				cfg_age <= cfg_age + 4'h1;
			end
		end
	end

	// pins follow led ticks, which may be four clocks apart, so wait for the age to saturate
	assign live = (cfg_age == 4'hF) && func[`FC_CLOCK_GATE];
	assign dark = (port_a_o == 24'h0) && (port_b_o == 24'h0);

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);

	a_bus_okay: assert property (hreadyout_o && !hresp_o)
		else $error("bus slave not ready or not okay");
	a_com_onehot: assert property ($onehot0(com_o))
		else $error("more than one row line on");
	a_gate_com: assert property (cfg_age == 4'hF && !func[`FC_CLOCK_GATE] |-> com_o == '0)
		else $error("row line on while the led clock is gated");
	a_groups_off: assert property (live && pm[6:4] == 3'h0 |-> dark)
		else $error("column lit with every colour group disabled");
	a_arr_invalid: assert property (live && (pm[2:0] == 3'h5 || pm[2:0] == 3'h7) |-> dark)
		else $error("column lit under an invalid arrangement");
	a_arr_both: assert property (live && pm[2:0] == `ARR_BOTH_PORTS_24PIN
		|-> port_a_o == port_b_o)
		else $error("ports differ in the both-ports arrangement");
	a_arr_port_a: assert property (live && pm[2:0] == `ARR_PORT_A_24PIN |-> port_b_o == 24'h0)
		else $error("port b lit in the port a arrangement");
	a_arr_mono: assert property (live && pm[2:0] == `ARR_MONOCHROME_16PIN
		|-> port_a_o[23:16] == 8'h00 && port_b_o == 24'h0)
		else $error("pin outside the monochrome set lit");
	a_luma_zero: assert property (live && !func[`FC_FULL_LUMA] && luma_level_i == 8'h00
		&& $past(luma_level_i) == 8'h00 |-> dark)
		else $error("column lit with zero luminance");
	a_rowsel_clear: assert property (wr_pend && wr_addr == `OFS_ROW_SELECT
		|-> ##[2:3] !led_irq_o)
		else $error("interrupt still high after a row select write");
endmodule

bind led_matrix_pwm_mode_ctrl led_pwm_mode_asserts #(.ROWS(ROWS)) u_chk (.clk_i(clk_i),
	.arst_n_i(arst_n_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
	.hwrite_i(hwrite_i), .hready_i(hready_i), .hwdata_i(hwdata_i), .hreadyout_o(hreadyout_o),
	.hresp_o(hresp_o), .luma_level_i(luma_level_i), .port_a_o(port_a_o), .port_b_o(port_b_o),
	.com_o(com_o), .led_irq_o(led_irq_o));
`default_nettype wire

// File: bench/led_matrix_model.sv
// stand-in for the led matrix: counts lit clock cycles of a few columns and of the rows
// assumes the pins are sampled on the block clock; the matrix only listens
`timescale 1ns/1ps
`default_nettype none

module led_matrix_model #(
	parameter ROWS = 8
) (
	// clock, reset and window clear
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic clr_i,
	// matrix pins
	input wire logic [23:0] port_a_i,
	input wire logic [23:0] port_b_i,
	input wire logic [ROWS-1:0] com_i,
	// lit cycle counts since the last clear
	output logic [15:0] cnt_a0_o,
	output logic [15:0] cnt_a8_o,
	output logic [15:0] cnt_a16_o,
	output logic [15:0] cnt_b0_o,
	output logic [15:0] cnt_com_o
);
	// one column per colour lane is enough, since a lane shares one level
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i || clr_i) begin
			cnt_a0_o <= 16'h0;
			cnt_a8_o <= 16'h0;
			cnt_a16_o <= 16'h0;
			cnt_b0_o <= 16'h0;
			cnt_com_o <= 16'h0;
		end else begin
			cnt_a0_o <= cnt_a0_o + 16'(port_a_i[0]);
			cnt_a8_o <= cnt_a8_o + 16'(port_a_i[8]);
			cnt_a16_o <= cnt_a16_o + 16'(port_a_i[16]);
			cnt_b0_o <= cnt_b0_o + 16'(port_b_i[0]);
			cnt_com_o <= cnt_com_o + 16'(|com_i);
		end
	end
endmodule
`default_nettype wire

// File: bench/test_led_matrix_pwm_mode_ctrl.sv
// self-checking bench for the led matrix pwm mode block
// assumes one ahb-lite master, a matrix model counting lit cycles, a 50 ns clock
`timescale 1ns/1ps
`default_nettype none
`include "led_pwm_mode_defs.vh"

module test_led_matrix_pwm_mode_ctrl;
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic clk_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic hsel_i = 1'b0;
	logic [7:0] haddr_i = 8'h00;
	logic [1:0] htrans_i = 2'h0;
	logic hwrite_i = 1'b0;
	logic [31:0] hwdata_i = 32'h0;
	logic [7:0] luma_level_i = 8'hFF;
	logic clr = 1'b0;
	logic [31:0] hrdata_o;
	logic hreadyout_o, hresp_o, led_irq_o;
	logic [23:0] port_a_o, port_b_o;
	logic [7:0] com_o;
	logic [15:0] cnt_a0, cnt_a8, cnt_a16, cnt_b0, cnt_com;
	int mismatches = 0;
	int num_checks = 0;

	always #25 clk_i = ~clk_i;

	led_matrix_pwm_mode_ctrl u_dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .hsel_i(hsel_i),
		.haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2),
		.hready_i(hreadyout_o), .hwdata_i(hwdata_i), .hrdata_o(hrdata_o),
		.hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .red_level_i(8'h80),
		.green_level_i(8'h40), .blue_level_i(8'h10), .luma_level_i(luma_level_i),
		.port_a_o(port_a_o), .port_b_o(port_b_o), .com_o(com_o), .led_irq_o(led_irq_o));
	led_matrix_model u_matrix (.clk_i(clk_i), .arst_n_i(arst_n_i), .clr_i(clr),
		.port_a_i(port_a_o), .port_b_i(port_b_o), .com_i(com_o), .cnt_a0_o(cnt_a0),
		.cnt_a8_o(cnt_a8), .cnt_a16_o(cnt_a16), .cnt_b0_o(cnt_b0), .cnt_com_o(cnt_com));

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task summarize;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task wait_ready;
		int n;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (hreadyout_o !== 1'b1 && n < 50);
		if (hreadyout_o !== 1'b1) begin
			mismatches++;
			summarize();
		end
	endtask

	task bus(input logic [7:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rd);
		haddr_i <= a;
		hwrite_i <= w;
		hsel_i <= 1'b1;
		htrans_i <= 2'h2;
		wait_ready();
		htrans_i <= 2'h0;
		hsel_i <= 1'b0;
		hwdata_i <= wd;
		wait_ready();
		rd = hrdata_o;
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] unused;
		bus(a, 1'b1, d, unused);
	endtask

	task rd_check(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] v;
		bus(a, 1'b0, 32'h0, v);
		check(v, exp);
	endtask

	task wait_irq;
		int n;
		n = 0;
		while (led_irq_o !== 1'b1 && n < 600) begin
			@(posedge clk_i);
			n++;
		end
		check(led_irq_o, 1'b1);
		if (led_irq_o !== 1'b1)
			summarize();
	endtask

	// a row is 260 ticks at divider 0, so any 260-cycle window holds exactly one row
	task show(input logic [7:0] pm, fc, luma, input logic [15:0] r, g, b, pb, com);
		luma_level_i <= luma;
		wr(`OFS_PWM_WORD, {pm, 24'h0});
		wr(`OFS_LED_CONTROL_WORD, {24'h0, fc});
		wr(`OFS_OUTPUT_CTRL, 32'h1);
		repeat (300) @(posedge clk_i);
		clr <= 1'b1;
		@(posedge clk_i);
		clr <= 1'b0;
		repeat (261) @(posedge clk_i);
		check(cnt_com, com);
		// with the clock stopped the columns are frozen, so only the rows are judged
		if (fc[`FC_CLOCK_GATE]) begin
			check(cnt_a0, r);
			check(cnt_a8, g);
			check(cnt_a16, b);
			check(cnt_b0, pb);
		end
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task reg_scenario;
		for (int i = 1; i < 8; i++) rd_check(8'(i * 4), 32'h0);
		wr(`OFS_PWM_WORD, 32'hFFFFFFFF);
		rd_check(`OFS_PWM_WORD, 32'h77000000);
		wr(`OFS_LED_CONTROL_WORD, 32'hFFFFFFFF);
		rd_check(`OFS_LED_CONTROL_WORD, 32'hF773F0DF);
		wr(`OFS_LED_CONTROL_WORD, 32'h0);
		wr(8'h04, 32'hFFFFFFFF);
		rd_check(8'h04, 32'h0);
		wr(`OFS_IRQ_MASK, 32'hFFFFFFFF);
		rd_check(`OFS_IRQ_MASK, 32'h80);
		wr(`OFS_IRQ_MASK, 32'h0);
		wr(`OFS_ROW_SELECT, 32'hFFFFFFFF);
		rd_check(`OFS_ROW_SELECT, 32'h7);
	endtask

	task pin_scenario;
		show(8'h70, 8'h03, 8'hFF, 128, 64, 16, 128, 256);
		show(8'h70, 8'h43, 8'hFF, 64, 64, 16, 64, 256);
		show(8'h60, 8'h03, 8'hFF, 0, 64, 16, 0, 256);
		show(8'h00, 8'h03, 8'hFF, 0, 0, 0, 0, 256);
		show(8'h71, 8'h03, 8'hFF, 128, 64, 16, 0, 256);
		show(8'h72, 8'h03, 8'hFF, 0, 0, 0, 128, 256);
		show(8'h73, 8'h03, 8'hFF, 0, 0, 16, 128, 256);
		show(8'h74, 8'h03, 8'hFF, 128, 64, 0, 0, 256);
		show(8'h75, 8'h03, 8'hFF, 0, 0, 0, 0, 256);
		show(8'h76, 8'h03, 8'hFF, 128, 128, 0, 0, 256);
		show(8'h70, 8'h01, 8'h20, 32, 32, 16, 32, 256);
		show(8'h70, 8'h01, 8'h00, 0, 0, 0, 0, 256);
		show(8'h70, 8'h0B, 8'hFF, 128, 64, 16, 128, 256);
		show(8'h70, 8'h13, 8'hFF, 128, 64, 16, 128, 260);
		show(8'h70, 8'h1B, 8'hFF, 128, 64, 16, 128, 259);
		show(8'h70, 8'h02, 8'hFF, 0, 0, 0, 0, 0);
	endtask

	task irq_scenario;
		// restart the row so the first row end lands well inside the wait below
		wr(`OFS_ROW_SELECT, 32'h0);
		wr(`OFS_LED_CONTROL_WORD, 32'h85);
		repeat (300) @(posedge clk_i);
		rd_check(`OFS_IRQ_STATUS, 32'h80);
		check(led_irq_o, 1'b0);
		rd_check(`OFS_OUTPUT_CTRL, 32'h0);
		wr(`OFS_IRQ_MASK, 32'h80);
		wait_irq();
		wr(`OFS_IRQ_STATUS, 32'h80);
		rd_check(`OFS_IRQ_STATUS, 32'h0);
		check(led_irq_o, 1'b0);
		wait_irq();
		wr(`OFS_ROW_SELECT, 32'h3);
		rd_check(`OFS_IRQ_STATUS, 32'h0);
		rd_check(`OFS_ROW_SELECT, 32'h3);
		wr(`OFS_LED_CONTROL_WORD, 32'h81);
		wr(`OFS_OUTPUT_CTRL, 32'h1);
		repeat (300) @(posedge clk_i);
		rd_check(`OFS_IRQ_STATUS, 32'h80);
		rd_check(`OFS_OUTPUT_CTRL, 32'h1);
		wr(`OFS_IRQ_STATUS, 32'h80);
		wr(`OFS_LED_CONTROL_WORD, 32'h01);
		repeat (300) @(posedge clk_i);
		rd_check(`OFS_IRQ_STATUS, 32'h0);
		check(led_irq_o, 1'b0);
	endtask

	initial begin
		repeat (10) @(posedge clk_i);
		arst_n_i <= 1'b1;
		@(posedge clk_i);
		reg_scenario();
		pin_scenario();
		irq_scenario();
		summarize();
	end
endmodule
`default_nettype wire
